// ### rtl/dsc_pkg.sv
/*
  Constants for the delta-sigma converter control block: register map, field positions,
  reset values and clock figures.
  Assumes a 20 MHz system clock and an AXI4-Lite master with 32-bit data.
*/
// What this block does
// - Converter unpowered until power-down and sleep clear.
// - Reset bit high then low starts conversion.
// - Device sets done flag when conversion finishes.
// - Done sets request flag; interrupt needs both enables.
// - Hold off: each result overwrites result registers.
// - Hold on: keep last result, discard later.
// - Source clock is system clock, direct or divided.
// - Reference select field routes positive reference.
// - Power-down switches converter off regardless inputs.
// - Result is 24-bit two's complement, sign MSB.
// - Out-of-range inputs saturate to extreme codes.
// - Code equals input over reference times 2^23.
// - Reset bit high holds filter, aborts conversion.
// - Hold on: no interrupt, done flag unchanged.
// - Divider all ones bypasses; else divide 2(n+1).
`default_nettype none

package dsc_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses.
  // ---------------------------------------------------------------
  localparam int unsigned AW         = 6;
  localparam logic [5:0]  ADDR_CTRL0 = 6'h00;
  localparam logic [5:0]  ADDR_CTRL1 = 6'h04;
  localparam logic [5:0]  ADDR_CLK   = 6'h08;
  localparam logic [5:0]  ADDR_GAIN  = 6'h0c;
  localparam logic [5:0]  ADDR_ROUTE = 6'h10;
  localparam logic [5:0]  ADDR_CHAN  = 6'h14;
  localparam logic [5:0]  ADDR_IRQ   = 6'h18;
  localparam logic [5:0]  ADDR_RES_L = 6'h1c;
  localparam logic [5:0]  ADDR_RES_M = 6'h20;
  localparam logic [5:0]  ADDR_RES_H = 6'h24;
  // ---------------------------------------------------------------
  // Field positions and reset values.
  // ---------------------------------------------------------------
  localparam int unsigned C1_EDGE    = 0;
  localparam int unsigned C1_SLEEP   = 1;
  localparam int unsigned C1_PD      = 2;
  localparam int unsigned C1_FRST    = 3;
  localparam int unsigned C1_DONE    = 4;
  localparam int unsigned C1_HOLD    = 5;
  localparam int unsigned C1_REF_LO  = 6;
  localparam int unsigned IRQ_GLOBAL = 0;
  localparam int unsigned IRQ_CONV   = 1;
  localparam int unsigned IRQ_REQ    = 2;
  localparam logic [7:0]  CTRL1_RST  = 8'h04;
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [4:0]  DIV_BYPASS = 5'h1f;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  // ---------------------------------------------------------------
  // Result format and clock figures.
  // ---------------------------------------------------------------
  localparam int unsigned RES_W      = 24;
  localparam int unsigned FILT_W     = 28;
  localparam logic [23:0] RES_MAX    = 24'h7fffff;
  localparam logic [23:0] RES_MIN    = 24'h800000;
  localparam int unsigned SYS_HZ     = 20000000;
  localparam int unsigned MCLK_HZ    = 4000000;
endpackage

`default_nettype wire

// ### rtl/dsc_reg_if.sv
/*
  Register access carrier between the bus slave and the register file.
  Assumes both ends run on the same clock.
*/
`default_nettype none

interface dsc_reg_if;
  logic       wr_stb;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_lane0;
  logic       wr_ok;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  logic       rd_ok;
  modport slv (output wr_stb, wr_addr, wr_data, wr_lane0, rd_addr,
               input wr_ok, rd_data, rd_ok);
  modport regs (input wr_stb, wr_addr, wr_data, wr_lane0, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface

`default_nettype wire

// ### rtl/dsc_clk_div.sv
/*
  Converter source clock enable: one pulse per source clock period.
  Assumes the divider field comes from a register on the same clock.
*/
`default_nettype none

module dsc_clk_div
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Divider field and enable out.
  input  wire logic [4:0] div_i,
  output logic            mclk_en_o
);
  logic [5:0] cnt_ff;
  logic [5:0] last;
  logic       bypass;

  // All ones passes the clock through; else period is 2*(n+1) cycles.
  assign bypass    = (div_i == dsc_pkg::DIV_BYPASS);
  assign last      = {div_i, 1'b1};
  assign mclk_en_o = bypass || (cnt_ff >= last);

  // Period counter.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_ff <= 6'h00;
    else if (mclk_en_o)
      cnt_ff <= 6'h00;
    else
      cnt_ff <= cnt_ff + 6'h01;
  end

  div_bypass_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    bypass |-> mclk_en_o) else $error("bypass divider did not pass clock");
  div_gap_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mclk_en_o && div_i == 5'h00 && $stable(div_i))
    |=> (!mclk_en_o || div_i != 5'h00) ##1 (mclk_en_o || div_i != 5'h00))
    else $error("divide by two period wrong");
endmodule

`default_nettype wire

// ### rtl/dsc_axil_slv.sv
/*
  AXI4-Lite slave front end: takes write address and data in either order, one write
  and one read at a time, and passes them to the register file over the carrier.
  Assumes the register file decodes and answers combinationally.
*/
`default_nettype none

module dsc_axil_slv
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Write channels.
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read channels.
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Register file side.
  dsc_reg_if.slv           rif
);
  logic       aw_full_ff;
  logic       w_full_ff;
  logic [5:0] aw_addr_ff;
  logic [7:0] w_data_ff;
  logic       w_lane_ff;
  logic       wr_go;
  logic       rd_go;

  // Each channel is held until both halves of the write are present.
  assign s_axi_awready = !aw_full_ff;
  assign s_axi_wready  = !w_full_ff;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go         = aw_full_ff && w_full_ff && !s_axi_bvalid;
  assign rd_go         = s_axi_arvalid && s_axi_arready;
  assign rif.wr_stb    = wr_go;
  assign rif.wr_addr   = aw_addr_ff;
  assign rif.wr_data   = w_data_ff;
  assign rif.wr_lane0  = w_lane_ff;
  assign rif.rd_addr   = s_axi_araddr;

  // Write path.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw_full_ff   <= 1'b0;
      w_full_ff    <= 1'b0;
      aw_addr_ff   <= 6'h00;
      w_data_ff    <= 8'h00;
      w_lane_ff    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dsc_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_ff)
      begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_ff)
      begin
        w_full_ff <= 1'b1;
        w_data_ff <= s_axi_wdata[7:0];
        w_lane_ff <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        aw_full_ff   <= 1'b0;
        w_full_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= rif.wr_ok ? dsc_pkg::RESP_OKAY : dsc_pkg::RESP_SLV;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read path: data is captured at the address handshake.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= dsc_pkg::RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h0, rif.rd_data};
      s_axi_rresp  <= rif.rd_ok ? dsc_pkg::RESP_OKAY : dsc_pkg::RESP_SLV;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

`default_nettype wire

// ### rtl/dsc_top.sv
/*
  Digital control of a 24-bit delta-sigma converter: power and sleep gating, start by
  filter reset pulse, done and interrupt request flags, result hold, saturation,
  source clock divider and reference routing, behind an AXI4-Lite register file.
  Assumes the decimation filter runs on this clock and delivers one wide signed value
  per finished conversion with a one-cycle valid.
*/
// Decided for this implementation: the address map and the AXI4-Lite register port.
`default_nettype none

module dsc_top
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // AXI4-Lite write channels.
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Decimation filter result.
  input  wire logic        filt_valid_i,
  input  wire logic [27:0] filt_data_i,
  // Analog and filter control.
  output logic             analog_en_o,
  output logic             modulator_en_o,
  output logic             filter_rst_o,
  output logic             mclk_en_o,
  output logic [1:0]       pos_reference_select_o,
  output logic             edge_sel_o,
  output logic [3:0]       oversample_select_o,
  output logic [2:0]       filter_rate_mode_o,
  output logic [7:0]       gain_config_o,
  output logic [7:0]       input_route_config_o,
  output logic [3:0]       pos_channel_select_o,
  output logic [3:0]       neg_channel_select_o,
  // Interrupt.
  output logic             irq_o
);
  // ---------------------------------------------------------------
  // Declarations.
  // ---------------------------------------------------------------
  dsc_reg_if rif ();

  logic [7:0]  ctrl0_ff;
  logic [7:0]  ctrl1_ff;
  logic [4:0]  clk_ff;
  logic [7:0]  gain_ff;
  logic [7:0]  route_ff;
  logic [7:0]  chan_ff;
  logic [2:0]  irq_ff;
  logic [23:0] result_ff;
  logic        run_ff;
  logic        frst_prev_ff;
  logic [7:0]  nxt_ctrl1;
  logic [2:0]  nxt_irq;
  logic [23:0] nxt_result;
  logic        nxt_run;
  logic [7:0]  ctrl1_base;
  logic [2:0]  irq_base;
  logic        wr_ctrl0;
  logic        wr_ctrl1;
  logic        wr_clk;
  logic        wr_gain;
  logic        wr_route;
  logic        wr_chan;
  logic        wr_irq;
  logic        powered;
  logic        hold;
  logic        frst;
  logic        start;
  logic        done_evt;
  logic        accept;
  logic        over;
  logic        under;
  logic [23:0] sat;
  logic        rd_rw;
  logic        rd_res;

  // ---------------------------------------------------------------
  // Bus slave and source clock divider.
  // ---------------------------------------------------------------
  dsc_axil_slv u_slv
  (
    .clk_i         (clk_i),
    .rst_b_i       (rst_b_i),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rif           (rif)
  );

  // Source clock enable, direct or divided system clock.
  dsc_clk_div u_div
  (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .div_i     (clk_ff),
    .mclk_en_o (mclk_en_o)
  );

  // ---------------------------------------------------------------
  // Write decode: only byte lane 0 carries register data.
  // ---------------------------------------------------------------
  assign wr_ctrl0 = rif.wr_stb && rif.wr_lane0 && (rif.wr_addr == dsc_pkg::ADDR_CTRL0);
  assign wr_ctrl1 = rif.wr_stb && rif.wr_lane0 && (rif.wr_addr == dsc_pkg::ADDR_CTRL1);
  assign wr_clk   = rif.wr_stb && rif.wr_lane0 && (rif.wr_addr == dsc_pkg::ADDR_CLK);
  assign wr_gain  = rif.wr_stb && rif.wr_lane0 && (rif.wr_addr == dsc_pkg::ADDR_GAIN);
  assign wr_route = rif.wr_stb && rif.wr_lane0 && (rif.wr_addr == dsc_pkg::ADDR_ROUTE);
  assign wr_chan  = rif.wr_stb && rif.wr_lane0 && (rif.wr_addr == dsc_pkg::ADDR_CHAN);
  assign wr_irq   = rif.wr_stb && rif.wr_lane0 && (rif.wr_addr == dsc_pkg::ADDR_IRQ);

  // Writable addresses answer OKAY; results and holes answer SLVERR.
  assign rif.wr_ok = (rif.wr_addr <= dsc_pkg::ADDR_IRQ) && (rif.wr_addr[1:0] == 2'h0);

  // ---------------------------------------------------------------
  // Converter state.
  // ---------------------------------------------------------------
  // Power-down overrides sleep and filter reset; both must clear to run.
  assign powered = !ctrl1_ff[dsc_pkg::C1_PD] && !ctrl1_ff[dsc_pkg::C1_SLEEP];
  assign hold    = ctrl1_ff[dsc_pkg::C1_HOLD];
  assign frst    = ctrl1_ff[dsc_pkg::C1_FRST];
  assign start   = frst_prev_ff && !frst && powered;

  // A conversion counts only while started, powered and out of reset.
  assign done_evt = filt_valid_i && run_ff && powered && !frst;
  assign accept   = done_evt && !hold;

  // Run starts on the falling reset bit and drops when reset or unpowered.
  assign nxt_run = (!powered || frst) ? 1'b0 : (start ? 1'b1 : run_ff);

  // Saturate the wide filter value to the signed 24-bit code range.
  assign over  = !filt_data_i[27] && (filt_data_i[26:23] != 4'h0);
  assign under = filt_data_i[27] && (filt_data_i[26:23] != 4'hf);
  assign sat   = over ? dsc_pkg::RES_MAX :
                 (under ? dsc_pkg::RES_MIN : filt_data_i[23:0]);

  // Result changes only on an accepted conversion, frozen while held.
  assign nxt_result = accept ? sat : result_ff;

  // Hardware set of done and request wins over a software clear.
  assign ctrl1_base = wr_ctrl1 ? rif.wr_data : ctrl1_ff;
  assign nxt_ctrl1  = {ctrl1_base[7:5], ctrl1_base[4] | accept, ctrl1_base[3:0]};
  assign irq_base   = wr_irq ? rif.wr_data[2:0] : irq_ff;
  assign nxt_irq    = {irq_base[2] | accept, irq_base[1:0]};

  // Control and flag registers.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl1_ff     <= dsc_pkg::CTRL1_RST;
      irq_ff       <= 3'h0;
      run_ff       <= 1'b0;
      frst_prev_ff <= 1'b0;
      result_ff    <= 24'h000000;
    end
    else
    begin
      ctrl1_ff     <= nxt_ctrl1;
      irq_ff       <= nxt_irq;
      run_ff       <= nxt_run;
      frst_prev_ff <= frst;
      result_ff    <= nxt_result;
    end
  end

  // Plain configuration registers.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl0_ff <= dsc_pkg::BYTE_RST;
      clk_ff   <= 5'h00;
      gain_ff  <= dsc_pkg::BYTE_RST;
      route_ff <= dsc_pkg::BYTE_RST;
      chan_ff  <= dsc_pkg::BYTE_RST;
    end
    else
    begin
      ctrl0_ff <= wr_ctrl0 ? rif.wr_data : ctrl0_ff;
      clk_ff   <= wr_clk ? rif.wr_data[4:0] : clk_ff;
      gain_ff  <= wr_gain ? rif.wr_data : gain_ff;
      route_ff <= wr_route ? rif.wr_data : route_ff;
      chan_ff  <= wr_chan ? rif.wr_data : chan_ff;
    end
  end

  // ---------------------------------------------------------------
  // Outputs to the analog side.
  // ---------------------------------------------------------------
  assign analog_en_o            = !ctrl1_ff[dsc_pkg::C1_PD];
  assign modulator_en_o         = powered;
  assign filter_rst_o           = frst || !run_ff;
  assign pos_reference_select_o = ctrl1_ff[7:6];
  assign edge_sel_o             = ctrl1_ff[dsc_pkg::C1_EDGE];
  assign oversample_select_o    = ctrl0_ff[3:0];
  assign filter_rate_mode_o     = ctrl0_ff[6:4];
  assign gain_config_o          = gain_ff;
  assign input_route_config_o   = route_ff;
  assign pos_channel_select_o   = chan_ff[3:0];
  assign neg_channel_select_o   = chan_ff[7:4];
  assign irq_o = irq_ff[dsc_pkg::IRQ_REQ] && irq_ff[dsc_pkg::IRQ_CONV]
                 && irq_ff[dsc_pkg::IRQ_GLOBAL];

  // ---------------------------------------------------------------
  // Read decode.
  // ---------------------------------------------------------------
  assign rd_rw  = (rif.rd_addr <= dsc_pkg::ADDR_IRQ) && (rif.rd_addr[1:0] == 2'h0);
  assign rd_res = (rif.rd_addr == dsc_pkg::ADDR_RES_L) || (rif.rd_addr == dsc_pkg::ADDR_RES_M)
                  || (rif.rd_addr == dsc_pkg::ADDR_RES_H);
  assign rif.rd_ok = rd_rw || rd_res;

  // Result bytes are split low, middle, high across three words.
  assign rif.rd_data =
    (rif.rd_addr == dsc_pkg::ADDR_CTRL0) ? ctrl0_ff :
    (rif.rd_addr == dsc_pkg::ADDR_CTRL1) ? ctrl1_ff :
    (rif.rd_addr == dsc_pkg::ADDR_CLK)   ? {3'h0, clk_ff} :
    (rif.rd_addr == dsc_pkg::ADDR_GAIN)  ? gain_ff :
    (rif.rd_addr == dsc_pkg::ADDR_ROUTE) ? route_ff :
    (rif.rd_addr == dsc_pkg::ADDR_CHAN)  ? chan_ff :
    (rif.rd_addr == dsc_pkg::ADDR_IRQ)   ? {5'h00, irq_ff} :
    (rif.rd_addr == dsc_pkg::ADDR_RES_L) ? result_ff[7:0] :
    (rif.rd_addr == dsc_pkg::ADDR_RES_M) ? result_ff[15:8] :
    (rif.rd_addr == dsc_pkg::ADDR_RES_H) ? result_ff[23:16] :
    8'h00;

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  pwr_gate_a: assert property (
    modulator_en_o |-> !ctrl1_ff[dsc_pkg::C1_PD] && !ctrl1_ff[dsc_pkg::C1_SLEEP])
    else $error("modulator on while powered down or asleep");
  conv_start_a: assert property (
    $fell(frst) && powered && !wr_ctrl1 |=> run_ff && !filter_rst_o)
    else $error("reset pulse did not start a conversion");
  done_set_a: assert property (
    accept |=> ctrl1_ff[dsc_pkg::C1_DONE]) else $error("done flag not set");
  irq_raise_a: assert property (
    accept && irq_ff[1:0] == 2'h3 && !wr_irq |=> irq_o) else $error("interrupt not raised");
  result_upd_a: assert property (
    accept |=> result_ff == $past(sat)) else $error("result not updated");
  hold_keep_a: assert property (
    hold |=> $stable(result_ff)) else $error("held result changed");
  pd_off_a: assert property (
    ctrl1_ff[dsc_pkg::C1_PD] |-> !analog_en_o && !modulator_en_o)
    else $error("converter on during power-down");
  sat_high_a: assert property (
    accept && over |=> result_ff == dsc_pkg::RES_MAX) else $error("no positive saturation");
  sat_low_a: assert property (
    accept && under |=> result_ff == dsc_pkg::RES_MIN) else $error("no negative saturation");
  filt_abort_a: assert property (
    frst |-> filter_rst_o ##1 !run_ff) else $error("filter not held in reset");
  hold_flag_a: assert property (
    hold && !wr_ctrl1 && !wr_irq |=> $stable(ctrl1_ff[dsc_pkg::C1_DONE]) && $stable(irq_ff))
    else $error("flags moved while held");
endmodule

`default_nettype wire

// ### verification/dsc_top_test.sv
/*
  Self-checking bench for the converter control block: register access, power gating,
  start pulse, flags, interrupt, hold, saturation, divider and reference routing.
  Assumes the AXI4-Lite answer timing of the block and a 20 MHz clock.
*/
`default_nettype none

module dsc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals.
  // ----------------------------------------------------------------
  logic        clk_i = 1'b0, rst_b_i = 1'b0;
  logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, filt_valid_i = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [27:0] filt_data_i = 28'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, pos_reference_select_o;
  logic        analog_en_o, modulator_en_o, filter_rst_o, mclk_en_o, irq_o;
  logic        edge_sel_o;
  logic [2:0]  filter_rate_mode_o;
  logic [3:0]  oversample_select_o, pos_channel_select_o, neg_channel_select_o;
  logic [7:0]  gain_config_o, input_route_config_o;
  int          n_errors = 0, n_checks = 0, cycles = 0;

  dsc_top i_dut
  (
    .clk_i, .rst_b_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .filt_valid_i, .filt_data_i,
    .analog_en_o, .modulator_en_o, .filter_rst_o, .mclk_en_o, .pos_reference_select_o,
    .edge_sel_o, .oversample_select_o, .filter_rate_mode_o, .gain_config_o,
    .input_route_config_o, .pos_channel_select_o, .neg_channel_select_o, .irq_o
  );

  // Clock, and a cycle ceiling that cuts a hang short.
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks.
  // ----------------------------------------------------------------
  // Compares and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  // Write one byte; address and data are released each at its own handshake.
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clk_i);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge clk_i);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge clk_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask

  // Read one register and compare data and response.
  task automatic rd(input logic [5:0] a, input logic [7:0] ed, input logic [1:0] er);
    logic ta, t;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    t = 1'b0;
    while (!t)
    begin
      @(negedge clk_i);
      ta = s_axi_arvalid && s_axi_arready;
      t  = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge clk_i);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(d, {24'h0, ed});
    chk({30'h0, r}, {30'h0, er});
  endtask

  // One finished conversion from the filter.
  task automatic pulse(input logic [27:0] v);
    @(posedge clk_i);
    filt_data_i  <= v;
    filt_valid_i <= 1'b1;
    @(posedge clk_i);
    filt_valid_i <= 1'b0;
  endtask

  // Prints the verdict and ends the run.
  task automatic stop_test;
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial
  begin
    int         cnt;
    logic [4:0] divs [3] = '{5'h01, 5'h04, 5'h1f};
    logic [27:0] sat_in [2] = '{28'h0800000, 28'hf7fffff};
    logic [7:0] sat_hi [2] = '{8'h7f, 8'h80};
    logic [7:0] sat_lo [2] = '{8'hff, 8'h00};
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(dsc_pkg::ADDR_CTRL1, dsc_pkg::CTRL1_RST, dsc_pkg::RESP_OKAY);
    @(negedge clk_i);
    chk({30'h0, analog_en_o, filter_rst_o}, 32'h1);
    rd(6'h28, 8'h00, dsc_pkg::RESP_SLV);
    wr(dsc_pkg::ADDR_RES_L, 8'h5a, dsc_pkg::RESP_SLV);
    // Source clock enable rate for a table of divider values.
    for (int i = 0; i < 3; i++)
    begin
      wr(dsc_pkg::ADDR_CLK, {3'h0, divs[i]}, dsc_pkg::RESP_OKAY);
      cnt = 0;
      repeat (40)
      begin
        @(negedge clk_i);
        if (mclk_en_o === 1'b1) cnt++;
      end
      chk(cnt, 40 / (divs[i] == 5'h1f ? 1 : 2 * (divs[i] + 1)));
    end
    // Every reference select code reaches the pins.
    for (int i = 0; i < 4; i++)
    begin
      wr(dsc_pkg::ADDR_CTRL1, {i[1:0], 6'h05}, dsc_pkg::RESP_OKAY);
      @(negedge clk_i);
      chk({29'h0, pos_reference_select_o, edge_sel_o}, 2 * i + 1);
    end
    // Configure gains, routing, divider, rate and channels before waking.
    wr(dsc_pkg::ADDR_GAIN, 8'ha5, dsc_pkg::RESP_OKAY);
    wr(dsc_pkg::ADDR_ROUTE, 8'h3c, dsc_pkg::RESP_OKAY);
    wr(dsc_pkg::ADDR_CLK, 8'h1f, dsc_pkg::RESP_OKAY);
    wr(dsc_pkg::ADDR_CTRL0, 8'h52, dsc_pkg::RESP_OKAY);
    wr(dsc_pkg::ADDR_CHAN, 8'h71, dsc_pkg::RESP_OKAY);
    @(negedge clk_i);
    chk({gain_config_o, input_route_config_o, neg_channel_select_o, pos_channel_select_o,
         1'b0, filter_rate_mode_o, oversample_select_o}, 32'ha53c7152);
    // Wake into sleep, then start by a reset pulse.
    wr(dsc_pkg::ADDR_CTRL1, 8'h02, dsc_pkg::RESP_OKAY);
    @(negedge clk_i);
    chk({30'h0, analog_en_o, modulator_en_o}, 32'h2);
    wr(dsc_pkg::ADDR_CTRL1, 8'h08, dsc_pkg::RESP_OKAY);
    wr(dsc_pkg::ADDR_CTRL1, 8'h00, dsc_pkg::RESP_OKAY);
    repeat (2) @(negedge clk_i);
    chk({30'h0, modulator_en_o, filter_rst_o}, 32'h2);
    wr(dsc_pkg::ADDR_IRQ, 8'h03, dsc_pkg::RESP_OKAY);
    pulse(28'h0123456);
    rd(dsc_pkg::ADDR_CTRL1, 8'h10, dsc_pkg::RESP_OKAY);
    rd(dsc_pkg::ADDR_RES_L, 8'h56, dsc_pkg::RESP_OKAY);
    rd(dsc_pkg::ADDR_RES_M, 8'h34, dsc_pkg::RESP_OKAY);
    rd(dsc_pkg::ADDR_RES_H, 8'h12, dsc_pkg::RESP_OKAY);
    rd(dsc_pkg::ADDR_IRQ, 8'h07, dsc_pkg::RESP_OKAY);
    chk({31'h0, irq_o}, 32'h1);
    wr(dsc_pkg::ADDR_IRQ, 8'h06, dsc_pkg::RESP_OKAY);
    @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    // Out-of-range values clip to the extreme codes.
    for (int i = 0; i < 2; i++)
    begin
      pulse(sat_in[i]);
      rd(dsc_pkg::ADDR_RES_H, sat_hi[i], dsc_pkg::RESP_OKAY);
      rd(dsc_pkg::ADDR_RES_L, sat_lo[i], dsc_pkg::RESP_OKAY);
    end
    // Hold keeps the result and leaves flags and interrupt alone.
    wr(dsc_pkg::ADDR_IRQ, 8'h03, dsc_pkg::RESP_OKAY);
    wr(dsc_pkg::ADDR_CTRL1, 8'h20, dsc_pkg::RESP_OKAY);
    pulse(28'h0000011);
    rd(dsc_pkg::ADDR_RES_L, 8'h00, dsc_pkg::RESP_OKAY);
    rd(dsc_pkg::ADDR_CTRL1, 8'h20, dsc_pkg::RESP_OKAY);
    chk({31'h0, irq_o}, 32'h0);
    wr(dsc_pkg::ADDR_CTRL1, 8'h00, dsc_pkg::RESP_OKAY);
    pulse(28'h0000011);
    rd(dsc_pkg::ADDR_RES_L, 8'h11, dsc_pkg::RESP_OKAY);
    // Filter reset held high abandons conversions.
    wr(dsc_pkg::ADDR_CTRL1, 8'h08, dsc_pkg::RESP_OKAY);
    @(negedge clk_i);
    chk({31'h0, filter_rst_o}, 32'h1);
    pulse(28'h0000022);
    rd(dsc_pkg::ADDR_RES_L, 8'h11, dsc_pkg::RESP_OKAY);
    rd(dsc_pkg::ADDR_CTRL1, 8'h08, dsc_pkg::RESP_OKAY);
    // Power-down switches the converter off and ignores results.
    wr(dsc_pkg::ADDR_CTRL1, 8'h04, dsc_pkg::RESP_OKAY);
    @(negedge clk_i);
    chk({30'h0, analog_en_o, filter_rst_o}, 32'h1);
    pulse(28'h0000033);
    rd(dsc_pkg::ADDR_RES_L, 8'h11, dsc_pkg::RESP_OKAY);
    stop_test();
  end
endmodule

`default_nettype wire
